/* rtl/ceru_pkg.sv */
/*
 * constants for the compare / execute-indirect / reset execution unit:
 * opcodes, opcode masks, status bit positions and register map.
 * assumes a 16-bit word machine, status bit 0 is the lsb of the port.
 */
package ceru_pkg;
    // ****************************************************************
    // opcodes and decode masks
    // ****************************************************************
    localparam logic [15:0] OP_EXEC = 16'h0480;
    localparam logic [15:0] OP_EXEC_MASK = 16'hFFC0;
    localparam logic [15:0] OP_CMPW = 16'h8000;
    localparam logic [15:0] OP_CMPB = 16'h9000;
    localparam logic [15:0] OP_FMT1_MASK = 16'hF000;
    localparam logic [15:0] OP_CMPI = 16'h0280;
    localparam logic [15:0] OP_CMPI_MASK = 16'hFFF0;
    localparam logic [15:0] OP_ONES = 16'h2000;
    localparam logic [15:0] OP_ZEROS = 16'h2400;
    localparam logic [15:0] OP_FMT3_MASK = 16'hFC00;
    localparam logic [15:0] OP_RESET = 16'h0360;
    // ****************************************************************
    // status register layout
    // ****************************************************************
    localparam int ST_LGT = 0;
    localparam int ST_AGT = 1;
    localparam int ST_EQ = 2;
    localparam int ST_CARRY = 3;
    localparam int ST_OVF = 4;
    localparam int ST_PAR = 5;
    localparam int ST_PRIV = 7;
    localparam int ST_MASK_LO = 12;
    localparam logic [15:0] ST_RESET = 16'h0000;
    localparam logic [3:0] MASK_CLEAR = 4'h0;
    // ****************************************************************
    // register port map (word offsets)
    // ****************************************************************
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STAT = 4'h1;
    localparam logic [3:0] REG_IRQ_MASK = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam int IRQ_COMPARE = 0;
    localparam int IRQ_RESET = 1;
    localparam int IRQ_PRIV_ERR = 2;
    localparam int IRQ_WIDTH = 3;
endpackage

/* rtl/ceru_unit.sv */
/*
 * compare, execute-indirect and reset-instruction execution unit.
 * assumes a sequencer hands in one instruction word with its operands
 * already fetched (src, dst, the next word) on a one-cycle strobe;
 * answers one cycle later with flags, pc advance and side effects.
 */
// Decided for this implementation: the plain strobed port and the address map.
// Functional notes
// - execute-indirect runs its source operand as the current instruction.
// - extra words of an indirect multiword instruction follow the execute-indirect word.
// - pc advances one, two or three words by executed instruction length.
// - indirect jump is relative to execute-indirect location; branches always taken.
// - execute-indirect alters no flags; executed instruction updates flags normally.
// - compares keep operands; arithmetic is signed, logical is unsigned.
// - word compare: unsigned sets logical-greater, signed sets arithmetic-greater and equal.
// - byte compare uses word basis; parity set when source byte has odd ones.
// - byte operand from workspace register uses its most significant byte.
// - byte compare updates four flags; word and immediate compare update three.
// - compare-immediate compares a register with the word following the instruction.
// - ones-mask compare: equal when all masked destination bits are one.
// - zeros-mask compare: equal when all masked destination bits are zero.
// - reset instruction clears the interrupt mask to zero.
// - reset clears pending interrupts, stops line clock, resets attached devices.
// - microprocessor variant only signals reset decode; external hardware acts. (here it also clears the interrupt mask)
// - minicomputer variant with privileged bit set raises error, no reset.
`timescale 1ns/1ps
module ceru_unit #(
    parameter bit MICRO_VARIANT = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // instruction issue
    input wire logic issue,
    input wire logic [15:0] instr,
    input wire logic [15:0] src_op,
    input wire logic [15:0] dst_op,
    input wire logic src_is_reg,
    input wire logic dst_is_reg,
    input wire logic [15:0] next_word,
    input wire logic [3:0] exec_len,
    input wire logic [15:0] instr_pc,
    // pending interrupt lines from outside
    input wire logic [15:0] irq_pending_in,
    // results
    output logic done,
    output logic [15:0] pc_next,
    output logic [15:0] exec_word,
    output logic exec_taken,
    output logic reset_decoded,
    output logic io_reset,
    output logic line_clock_stop,
    output logic pending_clear,
    output logic priv_error,
    output logic [15:0] status_out,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq
);
    // ****************************************************************
    // decode
    // ****************************************************************
    // execute-indirect substitutes the source word as the opcode
    logic is_exec;
    logic [15:0] op_word;
    assign is_exec = (instr & ceru_pkg::OP_EXEC_MASK) == ceru_pkg::OP_EXEC;
    assign op_word = is_exec ? src_op : instr;

    logic d_cmpw, d_cmpb, d_cmpi, d_ones, d_zeros, d_reset;
    assign d_cmpw = (op_word & ceru_pkg::OP_FMT1_MASK) == ceru_pkg::OP_CMPW;
    assign d_cmpb = (op_word & ceru_pkg::OP_FMT1_MASK) == ceru_pkg::OP_CMPB;
    assign d_cmpi = (op_word & ceru_pkg::OP_CMPI_MASK) == ceru_pkg::OP_CMPI;
    assign d_ones = (op_word & ceru_pkg::OP_FMT3_MASK) == ceru_pkg::OP_ONES;
    assign d_zeros = (op_word & ceru_pkg::OP_FMT3_MASK) == ceru_pkg::OP_ZEROS;
    assign d_reset = op_word == ceru_pkg::OP_RESET;

    // ****************************************************************
    // compare datapath
    // ****************************************************************
    // operands for the executed compare; register-mode byte is the high byte
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0] byte_a;
    logic [7:0] byte_b;
    // indirect compares take their source from the word after the execute
    logic [15:0] src_eff;
    assign src_eff = is_exec ? next_word : src_op;
    // byte operands from memory are assumed delivered in the high byte too
    assign byte_a = src_is_reg ? src_eff[15:8] : src_eff[15:8];
    assign byte_b = dst_is_reg ? dst_op[15:8] : dst_op[15:8];
    // indirect compares get their operands through next_word/dst_op
    assign cmp_a = d_cmpi ? dst_op : src_eff;
    assign cmp_b = d_cmpi ? next_word : dst_op;

    logic lgt_w, agt_w, eq_w, lgt_b, agt_b, eq_b, par_b, eq_ones, eq_zeros;
    assign lgt_w = cmp_a > cmp_b;
    assign agt_w = $signed(cmp_a) > $signed(cmp_b);
    assign eq_w = cmp_a == cmp_b;
    assign lgt_b = byte_a > byte_b;
    assign agt_b = $signed(byte_a) > $signed(byte_b);
    assign eq_b = byte_a == byte_b;
    assign par_b = ^byte_a;
    assign eq_ones = (dst_op & src_eff) == src_eff;
    assign eq_zeros = (dst_op & src_eff) == 16'h0000;

    // ****************************************************************
    // status register
    // ****************************************************************
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic priv_block;
    assign priv_block = !MICRO_VARIANT && status_reg[ceru_pkg::ST_PRIV];

    // only the flags each compare owns are touched; operands are never written
    always_comb begin
        status_next = status_reg;
        if (issue) begin
            if (d_cmpw || d_cmpi) begin
                status_next[ceru_pkg::ST_LGT] = lgt_w;
                status_next[ceru_pkg::ST_AGT] = agt_w;
                status_next[ceru_pkg::ST_EQ] = eq_w;
            end else if (d_cmpb) begin
                status_next[ceru_pkg::ST_LGT] = lgt_b;
                status_next[ceru_pkg::ST_AGT] = agt_b;
                status_next[ceru_pkg::ST_EQ] = eq_b;
                status_next[ceru_pkg::ST_PAR] = par_b;
            end else if (d_ones) begin
                status_next[ceru_pkg::ST_EQ] = eq_ones;
            end else if (d_zeros) begin
                status_next[ceru_pkg::ST_EQ] = eq_zeros;
            end else if (d_reset && !priv_block) begin
                status_next[15:ceru_pkg::ST_MASK_LO] = ceru_pkg::MASK_CLEAR;
            end
        end
        // the execute word itself never changes flags
    end

    // software write wins over the issue's flag update: issue and write are not expected together
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status_reg <= ceru_pkg::ST_RESET;
        end else if (reg_wr && reg_addr == ceru_pkg::REG_STATUS) begin
            status_reg <= reg_wdata;
        end else begin
            status_reg <= status_next;
        end
    end
    assign status_out = status_reg;

    // ****************************************************************
    // pc, execute outputs and reset side effects
    // ****************************************************************
    // pc steps over the execute word plus any extra words
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            done <= 1'b0;
            pc_next <= 16'h0000;
            exec_word <= 16'h0000;
            exec_taken <= 1'b0;
        end else begin
            done <= issue;
            exec_taken <= issue && is_exec;
            if (issue) begin
                exec_word <= op_word;
                if (is_exec) begin
                    // jump displacement is relative to the execute word
                    pc_next <= instr_pc + {11'h000, exec_len, 1'b0};
                end else if (d_cmpi) begin
                    pc_next <= instr_pc + 16'h0004;
                end else begin
                    pc_next <= instr_pc + 16'h0002;
                end
            end
        end
    end

    // reset side pulses last one cycle; of these the micro variant only flags decode
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reset_decoded <= 1'b0;
            io_reset <= 1'b0;
            line_clock_stop <= 1'b0;
            pending_clear <= 1'b0;
            priv_error <= 1'b0;
        end else begin
            reset_decoded <= issue && d_reset;
            io_reset <= issue && d_reset && !MICRO_VARIANT && !priv_block;
            line_clock_stop <= issue && d_reset && !MICRO_VARIANT && !priv_block;
            pending_clear <= issue && d_reset && !MICRO_VARIANT && !priv_block
                && (irq_pending_in != 16'h0000);
            priv_error <= issue && d_reset && priv_block;
        end
    end

    // ****************************************************************
    // interrupt status, mask and register read
    // ****************************************************************
    logic [ceru_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
    logic [ceru_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
    logic [ceru_pkg::IRQ_WIDTH-1:0] irq_events;
    // bit 0 is spare: compares raise no event of their own
    assign irq_events = {priv_error, reset_decoded, 1'b0};

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg
                & ~((reg_wr && reg_addr == ceru_pkg::REG_IRQ_STAT) ?
                    reg_wdata[ceru_pkg::IRQ_WIDTH-1:0] : '0)) | irq_events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_mask_reg <= '0;
        end else if (reg_wr && reg_addr == ceru_pkg::REG_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[ceru_pkg::IRQ_WIDTH-1:0];
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ceru_pkg::REG_STATUS: reg_rdata <= status_reg;
                ceru_pkg::REG_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_reg};
                ceru_pkg::REG_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_reg};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_exec_flags_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && is_exec && !(d_cmpw || d_cmpb || d_cmpi || d_ones || d_zeros || d_reset)
        && !reg_wr |=> status_reg == $past(status_reg))
        else $error("execute-indirect changed flags");
    a_word_cmp_lgt: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpw && !reg_wr |=> status_reg[0] == ($past(cmp_a) > $past(cmp_b)))
        else $error("word compare logical flag wrong");
    a_word_cmp_eq: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpw && !reg_wr |=> status_reg[2] == ($past(cmp_a) == $past(cmp_b)))
        else $error("word compare equal flag wrong");
    a_byte_parity: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpb && !reg_wr |=> status_reg[5] == ^$past(src_eff[15:8]))
        else $error("byte compare parity wrong");
    a_word_par_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && (d_cmpw || d_cmpi) && !reg_wr |=> $stable(status_reg[5]))
        else $error("word compare touched parity");
    a_ones_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_ones && !reg_wr |=> status_reg[2] == (($past(dst_op)
        & $past(src_eff)) == $past(src_eff)))
        else $error("ones-mask compare wrong");
    a_zeros_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_zeros && !reg_wr |=> status_reg[2] == (($past(dst_op)
        & $past(src_eff)) == 16'h0000))
        else $error("zeros-mask compare wrong");
    a_reset_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_reset && !priv_block && !reg_wr |=> status_reg[15:12] == 4'h0)
        else $error("reset did not clear mask");
    a_reset_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_reset |=> reset_decoded ##1 !reset_decoded || (issue && d_reset))
        else $error("reset indication not one cycle");
    a_priv_block: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_reset && priv_block |=> priv_error && !io_reset && !line_clock_stop)
        else $error("privileged reset not refused");
    a_exec_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && is_exec |=> pc_next == $past(instr_pc) + {11'h000, $past(exec_len), 1'b0})
        else $error("execute pc advance wrong");
    // byte logical flag
    a_byte_cmp_lgt: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpb && !reg_wr |=> status_reg[0] == ($past(byte_a) > $past(byte_b)))
        else $error("byte compare logical flag wrong");
    // word arithmetic flag
    a_word_cmp_agt: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpw && !reg_wr |=> status_reg[1] == $past($signed(cmp_a) > $signed(cmp_b)))
        else $error("word compare arithmetic flag wrong");
    // compares leave upper status alone
    a_cmp_upper_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && (d_cmpw || d_cmpb || d_cmpi || d_ones || d_zeros) && !reg_wr
        |=> $stable(status_reg[15:6])) else $error("compare touched upper status");
    // mask compares own only equal
    a_mask_only_eq: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && (d_ones || d_zeros) && !reg_wr |=> $stable(status_reg[1:0]))
        else $error("mask compare touched greater flags");
    // immediate equal flag
    a_imm_cmp_eq: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpi && !reg_wr |=> status_reg[2] == ($past(dst_op) == $past(next_word)))
        else $error("immediate compare equal flag wrong");
    // immediate steps over its operand
    a_imm_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_cmpi && !is_exec |=> pc_next == $past(instr_pc) + 16'h0004)
        else $error("immediate pc advance wrong");
    // answer one cycle after issue
    a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue |=> done)
        else $error("done missing after issue");
    // executed word is the source
    a_exec_word: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && is_exec |=> exec_word == $past(src_op) && exec_taken)
        else $error("execute word not handed on");
    // mask kept outside reset
    a_mask_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && !d_reset && !reg_wr |=> $stable(status_reg[15:12]))
        else $error("mask changed without reset");
    // ****************************************************************
    // reset side effects
    // ****************************************************************
    // line clock and devices stop together
    a_side_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
        io_reset == line_clock_stop)
        else $error("reset side pulses differ");
    // pending drop only with a full reset
    a_clear_with_io: assert property (@(posedge ref_clk) disable iff (!rstn)
        pending_clear |-> io_reset)
        else $error("pending cleared without reset");
    // micro variant drives no io reset, pending drop or error
    a_micro_no_io: assert property (@(posedge ref_clk) disable iff (!rstn)
        MICRO_VARIANT |-> !io_reset && !pending_clear && !priv_error)
        else $error("micro variant performed reset");
    // refused reset is latched as an event
    a_priv_err_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
        priv_error |=> irq_stat_reg[2])
        else $error("privilege error not latched");
    // micro variant still flags decode
    a_micro_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        issue && d_reset |=> reset_decoded)
        else $error("reset decode not flagged");
endmodule

/* tb/ceru_irq_source.sv */
/*
 * far-side model: interrupt sources, line clock and attached devices.
 * assumes the unit's side-effect outputs are one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
module ceru_irq_source (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // requests from the bench and pulses from the unit
    input wire logic [15:0] raise_lines,
    input wire logic pending_clear,
    input wire logic io_reset,
    input wire logic line_clock_stop,
    // state seen by the unit and the bench
    output logic [15:0] pending,
    output logic clock_running,
    output logic dev_reset_seen
);
    // ****************************************************************
    // pending lines latch until the unit asks for them to be dropped
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pending <= 16'h0000;
        end else if (pending_clear) begin
            pending <= 16'h0000;
        end else begin
            pending <= pending | raise_lines;
        end
    end

    // line clock runs from reset; attached devices note each reset pulse
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            clock_running <= 1'b1;
            dev_reset_seen <= 1'b0;
        end else begin
            if (line_clock_stop) clock_running <= 1'b0;
            if (io_reset) dev_reset_seen <= 1'b1;
        end
    end
endmodule

/* tb/ceru_unit_test.sv */
/*
 * self-checking bench for the compare / execute / reset unit.
 * assumes the unit answers one cycle after issue and after a read strobe.
 */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module ceru_unit_test;
    logic ref_clk = 0, rstn = 0, issue = 0, reg_wr = 0, reg_rd = 0;
    logic [15:0] instr = 0, src_op = 0, dst_op = 0, next_word = 0, reg_wdata = 0;
    logic [15:0] raise_lines = 0, pending, pc_next, exec_word, status_out, reg_rdata;
    logic [3:0] exec_len = 0, reg_addr = 0;
    logic done, exec_taken, reset_decoded, io_reset, line_clock_stop, pending_clear;
    logic priv_error, irq, clock_running, dev_reset_seen, m_reset, m_io;
    int err_count = 0, n_compared = 0, cycles = 0;
    logic [15:0] ws [6] = '{16'hFFFF, 16'h7FFF, 16'h8000, 16'h8000, 16'h7FFF, 16'h7FFF};
    logic [15:0] wd [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h7FFF, 16'h7FFF, 16'h8000};

    always #10 ref_clk = ~ref_clk;

    ceru_unit #(.MICRO_VARIANT(1'b0)) dut (.ref_clk(ref_clk), .rstn(rstn), .issue(issue),
        .instr(instr), .src_op(src_op), .dst_op(dst_op), .src_is_reg(1'b1),
        .dst_is_reg(1'b1), .next_word(next_word), .exec_len(exec_len),
        .instr_pc(16'h0100), .irq_pending_in(pending), .done(done), .pc_next(pc_next),
        .exec_word(exec_word), .exec_taken(exec_taken), .reset_decoded(reset_decoded),
        .io_reset(io_reset), .line_clock_stop(line_clock_stop),
        .pending_clear(pending_clear), .priv_error(priv_error), .status_out(status_out),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    // micro variant shares the stimulus; on reset it flags the decode and clears the interrupt mask, nothing more
    ceru_unit #(.MICRO_VARIANT(1'b1)) dut_micro (.ref_clk(ref_clk), .rstn(rstn),
        .issue(issue), .instr(instr), .src_op(src_op), .dst_op(dst_op), .src_is_reg(1'b1),
        .dst_is_reg(1'b1), .next_word(next_word), .exec_len(exec_len), .instr_pc(16'h0100),
        .irq_pending_in(pending), .done(), .pc_next(), .exec_word(), .exec_taken(),
        .reset_decoded(m_reset), .io_reset(m_io), .line_clock_stop(), .pending_clear(),
        .priv_error(), .status_out(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .irq());

    ceru_irq_source far (.ref_clk(ref_clk), .rstn(rstn), .raise_lines(raise_lines),
        .pending_clear(pending_clear), .io_reset(io_reset),
        .line_clock_stop(line_clock_stop), .pending(pending),
        .clock_running(clock_running), .dev_reset_seen(dev_reset_seen));

    // ****************************************************************
    // closing report and hang guard
    // ****************************************************************
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    // one issue, results looked at in the cycle they stand
    task automatic run(input logic [15:0] ins, s, d, nw, input logic [3:0] len);
        @(posedge ref_clk);
        issue <= 1'b1; instr <= ins; src_op <= s; dst_op <= d; next_word <= nw;
        exec_len <= len;
        @(posedge ref_clk);
        issue <= 1'b0;
        #1;
        `CHK("done", 1'b1, done)
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("read data", exp, reg_rdata)
    endtask

    // expected {equal, arith greater, logical greater} of a word compare
    function automatic logic [2:0] wflags(input logic [15:0] s, d);
        return {s == d, $signed(s) > $signed(d), s > d};
    endfunction

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(ceru_pkg::REG_STATUS, ceru_pkg::ST_RESET);
        rd(ceru_pkg::REG_IRQ_STAT, 16'h0000);
        // parity preset: word compares must leave it alone
        wr(ceru_pkg::REG_STATUS, 16'h0020);
        for (int i = 0; i < 6; i++) begin
            run(ceru_pkg::OP_CMPW, ws[i], wd[i], 16'h0000, 4'h1);
            `CHK("word flags", wflags(ws[i], wd[i]), status_out[2:0])
            `CHK("word parity kept", 1'b1, status_out[5])
            `CHK("word pc", 16'h0102, pc_next)
        end
        // byte compares with noise in the low bytes
        for (int i = 0; i < 6; i++) begin
            run(ceru_pkg::OP_CMPB, {ws[i][15:8], 8'hA5}, {wd[i][15:8], 8'h3C}, 0, 4'h1);
            `CHK("byte flags", wflags({ws[i][15:8], 8'h00}, {wd[i][15:8], 8'h00}),
                status_out[2:0])
            `CHK("byte parity", ^ws[i][15:8], status_out[5])
        end
        // immediate: register 2183 against F330 is arithmetic greater only
        run(ceru_pkg::OP_CMPI | 16'h0009, 16'h2183, 16'h2183, 16'hF330, 4'h1);
        `CHK("imm flags", 3'b010, status_out[2:0])
        `CHK("imm pc", 16'h0104, pc_next)
        // mask compares
        run(ceru_pkg::OP_ONES, 16'hC102, 16'hE306, 0, 4'h1);
        `CHK("ones hit", 1'b1, status_out[2])
        run(ceru_pkg::OP_ONES, 16'hC102, 16'hE301, 0, 4'h1);
        `CHK("ones miss", 1'b0, status_out[2])
        run(ceru_pkg::OP_ZEROS, 16'hC102, 16'h2301, 0, 4'h1);
        `CHK("zeros miss", 1'b0, status_out[2])
        run(ceru_pkg::OP_ZEROS, 16'hC102, 16'h2201, 0, 4'h1);
        `CHK("zeros hit", 1'b1, status_out[2])
        // execute of a jump word: flags untouched, word handed on
        run(ceru_pkg::OP_EXEC, 16'h1300, 0, 0, 4'h1);
        `CHK("exec seen", 1'b1, exec_taken)
        `CHK("exec word", 16'h1300, exec_word)
        `CHK("exec flags kept", 1'b1, status_out[2])
        `CHK("exec pc", 16'h0102, pc_next)
        // execute of a compare, then of a two-word immediate compare
        run(ceru_pkg::OP_EXEC, ceru_pkg::OP_CMPW, 16'h0000, 16'h7FFF, 4'h1);
        `CHK("exec cmp flags", 3'b011, status_out[2:0])
        run(ceru_pkg::OP_EXEC, ceru_pkg::OP_CMPI, 16'h0005, 16'h0005, 4'h2);
        `CHK("exec imm flags", 3'b100, status_out[2:0])
        `CHK("exec two pc", 16'h0104, pc_next)
        // reset instruction with all levels enabled and a line pending
        wr(ceru_pkg::REG_STATUS, 16'hF000);
        @(posedge ref_clk);
        raise_lines <= 16'h0020;
        @(posedge ref_clk);
        raise_lines <= 16'h0000;
        run(ceru_pkg::OP_RESET, 0, 0, 0, 4'h1);
        `CHK("reset seen", 1'b1, reset_decoded)
        `CHK("io reset", 1'b1, io_reset)
        `CHK("clock stop", 1'b1, line_clock_stop)
        `CHK("pending drop", 1'b1, pending_clear)
        `CHK("micro seen", 1'b1, m_reset)
        `CHK("micro no io", 1'b0, m_io)
        `CHK("no priv err", 1'b0, priv_error)
        `CHK("mask cleared", ceru_pkg::MASK_CLEAR, status_out[15:12])
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("far pending", 16'h0000, pending)
        `CHK("far clock", 1'b0, clock_running)
        `CHK("far devices", 1'b1, dev_reset_seen)
        // privileged attempt is refused with an error
        wr(ceru_pkg::REG_STATUS, 16'hF080);
        run(ceru_pkg::OP_RESET, 0, 0, 0, 4'h1);
        `CHK("priv err", 1'b1, priv_error)
        `CHK("priv io", 1'b0, io_reset)
        `CHK("priv clock", 1'b0, line_clock_stop)
        `CHK("priv mask kept", 4'hF, status_out[15:12])
        // interrupt status, mask and level output
        rd(ceru_pkg::REG_IRQ_STAT, 16'h0006);
        `CHK("irq masked", 1'b0, irq)
        wr(ceru_pkg::REG_IRQ_MASK, 16'h0006);
        #1;
        `CHK("irq raised", 1'b1, irq)
        rd(ceru_pkg::REG_IRQ_MASK, 16'h0006);
        wr(ceru_pkg::REG_IRQ_STAT, 16'h0002);
        #1;
        `CHK("irq one left", 1'b1, irq)
        wr(ceru_pkg::REG_IRQ_STAT, 16'h0004);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        rd(ceru_pkg::REG_IRQ_STAT, 16'h0000);
        rd(4'hF, 16'h0000);
        finish_test();
    end
endmodule
